// >>> verilog/pcs_codec_regs.svh
// Purpose: constants of the codec configuration and slot logic
// Assumes: included by bare name from design files
// Notes: offsets are 4-bit instruction addresses of the control port
// Notes on behaviour
// R1 - control byte bits 7..0: div hi, div lo, law, inv off, dly off, loops, amp
// R2 - instruction byte: bits 6..3 address, bit 2 read, bit 1 two-byte
// R3 - delay-off bit 0 delayed, 1 non-delayed; non-delayed after reset
// R4 - non-delayed slots start at the frame mark rising edge
// R5 - amp bit 1 disables receive amplifier in sleep; resets to 1
// R6 - invert-off bit resets to 0, giving mu-255 with law reset
// R7 - host programs divider bits to match master clock
// R8 - law and invert-off bits pick mu-255 or A-law with/without inversion
// R9 - inverted A-law: full scale 10101010, zero 11010101
// R10 - PCM bytes move most significant bit first
// R11 - voice loop alone loops receive into transmit, isolates voice input
// R12 - host disables hybrid balance before trusting voice loop
// R13 - digital loop returns received byte in each transmit slot
// R14 - decoder runs in digital loop; zero receive gain silences output
// R15 - latch pins reset as inputs, drivers off
// R16 - direction bit per latch, latch 0 at bit 7, bits 1..0 ignored
// R17 - output latch drives its value bit, latch 0 at bit 7
// R18 - latch value read gives input levels and programmed outputs
// R19 - host writes latch values then directions; spare pins as outputs
// R20 - slot byte: enable bit 7, port bit 6, slot in bits 5..0
// R21 - enable 0 disables the port, 1 enables it in its slot
// R22 - port bit picks port a or b, never both
// R23 - delayed mode counts 64 slots of 8 bits from the frame mark
// R24 - host sets slot 0 in non-delayed mode
// R25 - slot register write deactivates that direction at once
// R26 - new assignment live on second frame after chip select ends
// R27 - host computes transmit gain code from level
// R28 - zero transmit gain sends idle-noise codes
`ifndef PCS_CODEC_REGS_SVH
`define PCS_CODEC_REGS_SVH
`define PCS_A_CTRL 4'h0
`define PCS_A_LVAL 4'h1
`define PCS_A_LDIR 4'h2
`define PCS_A_RGAIN 4'h4
`define PCS_A_TGAIN 4'h5
`define PCS_A_RSLOT 4'h9
`define PCS_A_TSLOT 4'ha
`define PCS_B1_PWR 7
`define PCS_B1_RD 2
`define PCS_B1_TWO 1
`define PCS_C_LAW 5
`define PCS_C_INV 4
`define PCS_C_DLY 3
`define PCS_C_DLOOP 2
`define PCS_C_VLOOP 1
`define PCS_C_AMP 0
`define PCS_S_EN 7
`define PCS_S_PORT 6
`define PCS_CTRL_RST 8'h89
`define PCS_ZERO_RST 8'h00
`define PCS_LATCH_MASK 8'hfc
`define PCS_XOR_MU 8'h7f
`define PCS_XOR_AINV 8'h55
`define PCS_XOR_ANONE 8'h00
`define PCS_IDLE_RAW 8'h80
`define PCS_POS_LAST 9'h1ff
`endif

// >>> verilog/pcs_codec_pkg.sv
// Purpose: types of the codec configuration and slot logic
// Assumes: nothing
// Notes: one struct per block of state: slot tracker, bit clock side, core
package pcs_codec_pkg;
	typedef enum logic [1:0] {PH_FIRST = 2'b00, PH_SECOND = 2'b01} pcs_phase_t;
	typedef struct packed {
		logic mark_q, run, live;
		logic [1:0] frames;
		logic [8:0] pos;
		logic [7:0] assign_w;
	} pcs_slot_t;
	typedef struct packed {
		logic [3:0] tg_s1, tg_s2, tg_p;
		logic [1:0] lv_s1, lv_s2;
		logic [7:0] tx_sh, rx_byte;
		logic [6:0] rx_sh;
		logic tx_a, tx_b, oe_a, oe_b, tx_tgl;
		logic rx_samp, rx_port, rx_last, rx_tgl;
	} pcs_link_t;
	typedef struct packed {
		pcs_phase_t phase;
		logic [2:0] bit_cnt;
		logic [7:0] in_sh, b1, out_sh;
		logic cclk_q, co, co_oe, sleep, amp_en, iso;
		logic [1:0] pend, wr_tgl, cm_tgl;
		logic [7:0] ctrl, lval, ldir, rgain, tgain, rslot, tslot;
		logic [7:0] tx_word, rx_voice;
		logic [1:0] txq_s1, txq_s2;
		logic txq_p, rxq_p;
		logic [5:0] l_out, l_oe;
	} pcs_core_t;
endpackage

// >>> verilog/pcs_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: asynchronous inputs
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pcs_sync3 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] q_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1, s2, s3, q;
	} pcs_sync_t;
	pcs_sync_t s_ff, nxt_s;
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.s1 = pin_in;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s_ff.s2[i] == s_ff.s3[i])
				nxt_s.q[i] = s_ff.s3[i];
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	assign q_out = s_ff.q;
endmodule
`default_nettype wire

// >>> verilog/pcs_slot_track.sv
// Purpose: frame and time-slot tracker for one PCM direction
// Assumes: runs on the bit clock; event inputs are one-cycle pulses
// Notes: slot word is stable in the core domain when commit arrives
`timescale 1ns/1ps
`default_nettype none
`include "pcs_codec_regs.svh"
module pcs_slot_track (
	// clock and reset
	input wire logic link_clk_in,
	input wire logic arst_n_in,
	// frame and mode
	input wire logic mark_in,
	input wire logic delay_off_in,
	// assignment
	input wire logic wr_evt_in,
	input wire logic cm_evt_in,
	input wire logic [7:0] assign_in,
	// position
	output logic hit_out,
	output logic [2:0] bit_idx_out,
	output logic sof_out,
	output logic port_out
);
	pcs_codec_pkg::pcs_slot_t s_ff, nxt_s;
	logic rise, valid, live_now;
	logic [8:0] cur;
	always_comb
	begin
		nxt_s = s_ff;
		rise = mark_in & ~s_ff.mark_q;
		nxt_s.mark_q = mark_in;
		valid = 1'b0;
		cur = s_ff.pos;
		live_now = s_ff.live & ~wr_evt_in & ~cm_evt_in; // R25
		if (wr_evt_in)
			nxt_s.live = 1'b0;
		if (cm_evt_in)
		begin
			nxt_s.assign_w = assign_in;
			nxt_s.frames = 2'h2;
			nxt_s.live = 1'b0;
		end
		else if (rise && s_ff.frames != 2'h0)
		begin
			nxt_s.frames = s_ff.frames - 2'h1;
			if (s_ff.frames == 2'h1) // R26
			begin
				nxt_s.live = ~wr_evt_in;
				live_now = ~wr_evt_in;
			end
		end
		if (rise && delay_off_in)
		begin
			cur = 9'h000; // R4
			valid = 1'b1;
			nxt_s.pos = 9'h001;
			nxt_s.run = 1'b1;
		end
		else if (rise)
		begin
			nxt_s.pos = 9'h000; // R23
			nxt_s.run = 1'b1;
		end
		else if (s_ff.run)
		begin
			valid = 1'b1;
			nxt_s.pos = s_ff.pos + 9'h001;
			if (s_ff.pos == `PCS_POS_LAST)
				nxt_s.run = 1'b0;
		end
		hit_out = valid & live_now & s_ff.assign_w[`PCS_S_EN] &
			(cur[8:3] == s_ff.assign_w[5:0]); // R21 R23
		bit_idx_out = cur[2:0];
		sof_out = rise;
		port_out = s_ff.assign_w[`PCS_S_PORT];
	end
	always_ff @(posedge link_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	a_commit_quiet: assert property (@(posedge link_clk_in)
		disable iff (!arst_n_in)
		cm_evt_in |=> !hit_out [*2]) // R26
		else $error("slot hit right after commit");
	a_nodelay_start: assert property (@(posedge link_clk_in)
		disable iff (!arst_n_in)
		rise && delay_off_in && live_now && s_ff.assign_w[`PCS_S_EN] &&
		s_ff.assign_w[5:0] == 6'h00 |-> hit_out && bit_idx_out == 3'h0)
		else $error("non-delayed slot missed frame mark"); // R4
endmodule
`default_nettype wire

// >>> verilog/pcs_codec_top.sv
// Purpose: codec configuration registers and PCM time-slot logic
// Assumes: control port pins asynchronous; PCM pins synchronous to bit clock
// Notes: voice samples are sign-magnitude codes (bit 7 sign, 0x80 zero)
`timescale 1ns/1ps
`default_nettype none
`include "pcs_codec_regs.svh"
module pcs_codec_top (
	// clocks and reset
	input wire logic core_clk_in,
	input wire logic pcm_bit_clk_in,
	input wire logic arst_n_in,
	// serial control port
	input wire logic ctl_clk_in,
	input wire logic ctl_cs_n_in,
	input wire logic ctl_data_in,
	output logic ctl_data_out,
	output logic ctl_data_oe_out,
	// side latches
	input wire logic [5:0] side_latch_pin_in,
	output logic [5:0] side_latch_pin_out,
	output logic [5:0] side_latch_pin_oe_out,
	// PCM highway
	input wire logic tx_frame_mark_in,
	input wire logic rx_frame_mark_in,
	input wire logic rx_pcm_in_a_in,
	input wire logic rx_pcm_in_b_in,
	output logic tx_pcm_out_a_out,
	output logic tx_pcm_out_a_oe_out,
	output logic tx_pcm_out_b_out,
	output logic tx_pcm_out_b_oe_out,
	// voice path
	input wire logic [7:0] tx_voice_in,
	output logic [7:0] rx_voice_out,
	output logic tx_voice_iso_out,
	output logic rx_amp_en_out,
	// power and clocking
	output logic sleep_state_out,
	output logic [1:0] master_div_out
);
	pcs_codec_pkg::pcs_core_t c_ff, nxt_c;
	pcs_codec_pkg::pcs_link_t l_ff, nxt_l;
	logic [8:0] pin_s;
	logic [5:0] latch_s;
	logic cclk, cs_n, ci, cfall, crise;
	logic [7:0] byte_v, rd_v, wr_v, mask, src;
	logic tx_req, rx_rdy, analog;
	logic t_hit, t_sof, t_port, r_hit, r_sof, r_port;
	logic [2:0] t_bidx, r_bidx;
	logic [3:0] tg_evt;
	logic rx_bit;

	pcs_sync3 #(
		.WIDTH(9)
	) u_pins (
		.clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.pin_in({side_latch_pin_in, ctl_clk_in, ctl_cs_n_in, ctl_data_in}),
		.q_out(pin_s)
	);
	assign latch_s = pin_s[8:3];
	assign cclk = pin_s[2];
	assign cs_n = pin_s[1];
	assign ci = pin_s[0];

	// core domain: control port, registers, voice path
	always_comb
	begin
		nxt_c = c_ff;
		cfall = c_ff.cclk_q & ~cclk;
		crise = ~c_ff.cclk_q & cclk;
		nxt_c.cclk_q = cclk;
		byte_v = {c_ff.in_sh[6:0], ci};
		wr_v = byte_v;
		for (int i = 0; i < 6; i++) // R18
			rd_v[7-i] = c_ff.ldir[7-i] ? c_ff.lval[7-i] : latch_s[i];
		rd_v[1:0] = 2'b00;
		case (byte_v[6:3]) // R2
			`PCS_A_CTRL: rd_v = c_ff.ctrl;
			`PCS_A_LVAL: rd_v = rd_v;
			`PCS_A_LDIR: rd_v = c_ff.ldir;
			`PCS_A_RGAIN: rd_v = c_ff.rgain;
			`PCS_A_TGAIN: rd_v = c_ff.tgain;
			`PCS_A_RSLOT: rd_v = c_ff.rslot;
			`PCS_A_TSLOT: rd_v = c_ff.tslot;
			default: rd_v = 8'h00;
		endcase
		if (cs_n)
		begin
			// aborted bytes leave registers untouched
			nxt_c.bit_cnt = 3'h0;
			nxt_c.phase = pcs_codec_pkg::PH_FIRST;
			nxt_c.co_oe = 1'b0;
			nxt_c.cm_tgl = c_ff.cm_tgl ^ c_ff.pend; // R26
			nxt_c.pend = 2'b00;
		end
		else
		begin
			nxt_c.co_oe = c_ff.b1[`PCS_B1_RD] &
				(c_ff.phase == pcs_codec_pkg::PH_SECOND);
			if (cfall)
			begin
				nxt_c.in_sh = byte_v;
				nxt_c.bit_cnt = c_ff.bit_cnt + 3'h1;
			end
			if (cfall && c_ff.bit_cnt == 3'h7)
			begin
				case (c_ff.phase)
					pcs_codec_pkg::PH_FIRST:
					begin
						nxt_c.b1 = byte_v;
						nxt_c.sleep = byte_v[`PCS_B1_PWR];
						nxt_c.out_sh = rd_v;
						if (byte_v[`PCS_B1_TWO]) // R2
							nxt_c.phase = pcs_codec_pkg::PH_SECOND;
					end
					pcs_codec_pkg::PH_SECOND:
					begin
						nxt_c.phase = pcs_codec_pkg::PH_FIRST;
						nxt_c.co_oe = 1'b0;
						if (!c_ff.b1[`PCS_B1_RD])
						begin
							case (c_ff.b1[6:3])
								`PCS_A_CTRL: nxt_c.ctrl = wr_v; // R1
								`PCS_A_LVAL: nxt_c.lval = wr_v & `PCS_LATCH_MASK; // R17
								`PCS_A_LDIR: nxt_c.ldir = wr_v & `PCS_LATCH_MASK; // R16
								`PCS_A_RGAIN: nxt_c.rgain = wr_v;
								`PCS_A_TGAIN: nxt_c.tgain = wr_v;
								`PCS_A_RSLOT:
								begin
									nxt_c.rslot = wr_v; // R20
									nxt_c.wr_tgl[0] = ~c_ff.wr_tgl[0]; // R25
									nxt_c.pend[0] = 1'b1;
								end
								`PCS_A_TSLOT:
								begin
									nxt_c.tslot = wr_v; // R20
									nxt_c.wr_tgl[1] = ~c_ff.wr_tgl[1]; // R25
									nxt_c.pend[1] = 1'b1;
								end
								default: nxt_c.ctrl = c_ff.ctrl;
							endcase
						end
					end
					default: nxt_c.phase = pcs_codec_pkg::PH_FIRST;
				endcase
			end
			if (crise && c_ff.phase == pcs_codec_pkg::PH_SECOND &&
				c_ff.b1[`PCS_B1_RD])
			begin
				nxt_c.co = c_ff.out_sh[7];
				nxt_c.out_sh = {c_ff.out_sh[6:0], 1'b0};
			end
		end
		for (int i = 0; i < 6; i++)
		begin
			nxt_c.l_oe[i] = c_ff.ldir[7-i]; // R15 R16
			nxt_c.l_out[i] = c_ff.lval[7-i]; // R17
		end
		// word handshake with the bit clock side
		nxt_c.txq_s1 = {l_ff.rx_tgl, l_ff.tx_tgl};
		nxt_c.txq_s2 = c_ff.txq_s1;
		nxt_c.txq_p = c_ff.txq_s2[0];
		nxt_c.rxq_p = c_ff.txq_s2[1];
		tx_req = c_ff.txq_s2[0] ^ c_ff.txq_p;
		rx_rdy = c_ff.txq_s2[1] ^ c_ff.rxq_p;
		if (!c_ff.ctrl[`PCS_C_LAW]) // R8
			mask = `PCS_XOR_MU;
		else if (!c_ff.ctrl[`PCS_C_INV])
			mask = `PCS_XOR_AINV; // R9
		else
			mask = `PCS_XOR_ANONE;
		analog = ~c_ff.ctrl[`PCS_C_DLOOP] & c_ff.ctrl[`PCS_C_VLOOP];
		src = analog ? c_ff.rx_voice : tx_voice_in; // R11
		nxt_c.iso = analog; // R11
		if (tx_req)
			nxt_c.tx_word = (c_ff.tgain == 8'h00) ?
				(`PCS_IDLE_RAW ^ mask) : (src ^ mask); // R28
		if (rx_rdy)
			nxt_c.rx_voice = (c_ff.rgain == 8'h00) ?
				`PCS_IDLE_RAW : (l_ff.rx_byte ^ mask); // R14
		nxt_c.amp_en = ~(c_ff.sleep & c_ff.ctrl[`PCS_C_AMP]); // R5
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			c_ff <= '0;
			c_ff.ctrl <= `PCS_CTRL_RST; // R3 R5 R6
			c_ff.sleep <= 1'b1;
			c_ff.ldir <= `PCS_ZERO_RST; // R15
		end
		else
			c_ff <= nxt_c;
	end

	// bit clock domain: PCM shifting
	pcs_slot_track u_tx_track (
		.link_clk_in(pcm_bit_clk_in),
		.arst_n_in(arst_n_in),
		.mark_in(tx_frame_mark_in),
		.delay_off_in(l_ff.lv_s2[0]),
		.wr_evt_in(tg_evt[1]),
		.cm_evt_in(tg_evt[3]),
		.assign_in(c_ff.tslot),
		.hit_out(t_hit),
		.bit_idx_out(t_bidx),
		.sof_out(t_sof),
		.port_out(t_port)
	);
	pcs_slot_track u_rx_track (
		.link_clk_in(pcm_bit_clk_in),
		.arst_n_in(arst_n_in),
		.mark_in(rx_frame_mark_in),
		.delay_off_in(l_ff.lv_s2[0]),
		.wr_evt_in(tg_evt[0]),
		.cm_evt_in(tg_evt[2]),
		.assign_in(c_ff.rslot),
		.hit_out(r_hit),
		.bit_idx_out(r_bidx),
		.sof_out(r_sof),
		.port_out(r_port)
	);

	always_comb
	begin
		nxt_l = l_ff;
		nxt_l.tg_s1 = {c_ff.cm_tgl, c_ff.wr_tgl};
		nxt_l.tg_s2 = l_ff.tg_s1;
		nxt_l.tg_p = l_ff.tg_s2;
		tg_evt = l_ff.tg_s2 ^ l_ff.tg_p;
		nxt_l.lv_s1 = {c_ff.ctrl[`PCS_C_DLOOP], c_ff.ctrl[`PCS_C_DLY]};
		nxt_l.lv_s2 = l_ff.lv_s1;
		// core word is stable here: it only moves after this request
		if (t_sof)
		begin
			nxt_l.tx_sh = l_ff.lv_s2[1] ? l_ff.rx_byte : c_ff.tx_word; // R13
			nxt_l.tx_tgl = ~l_ff.tx_tgl;
		end
		nxt_l.oe_a = t_hit & ~t_port; // R22
		nxt_l.oe_b = t_hit & t_port; // R22
		// non-delayed bit 0 shares its edge with the load: use the new word
		nxt_l.tx_a = t_hit & ~t_port & nxt_l.tx_sh[3'h7 - t_bidx]; // R10
		nxt_l.tx_b = t_hit & t_port & nxt_l.tx_sh[3'h7 - t_bidx]; // R10
		// receive bits are taken one edge after they start
		nxt_l.rx_samp = r_hit;
		nxt_l.rx_port = r_port;
		nxt_l.rx_last = (r_bidx == 3'h7);
		rx_bit = l_ff.rx_port ? rx_pcm_in_b_in : rx_pcm_in_a_in; // R22
		if (l_ff.rx_samp)
		begin
			nxt_l.rx_sh = {l_ff.rx_sh[5:0], rx_bit}; // R10
			if (l_ff.rx_last)
			begin
				nxt_l.rx_byte = {l_ff.rx_sh, rx_bit};
				nxt_l.rx_tgl = ~l_ff.rx_tgl;
			end
		end
	end

	always_ff @(posedge pcm_bit_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			l_ff <= '0;
			l_ff.lv_s1 <= 2'b01;
			l_ff.lv_s2 <= 2'b01;
		end
		else
			l_ff <= nxt_l;
	end

	assign ctl_data_out = c_ff.co;
	assign ctl_data_oe_out = c_ff.co_oe;
	assign side_latch_pin_out = c_ff.l_out;
	assign side_latch_pin_oe_out = c_ff.l_oe;
	assign tx_pcm_out_a_out = l_ff.tx_a;
	assign tx_pcm_out_a_oe_out = l_ff.oe_a;
	assign tx_pcm_out_b_out = l_ff.tx_b;
	assign tx_pcm_out_b_oe_out = l_ff.oe_b;
	assign rx_voice_out = c_ff.rx_voice;
	assign tx_voice_iso_out = c_ff.iso;
	assign rx_amp_en_out = c_ff.amp_en;
	assign sleep_state_out = c_ff.sleep;
	assign master_div_out = c_ff.ctrl[7:6];

	sequence s_tx_first;
		t_hit && t_bidx == 3'h0 && !t_port;
	endsequence
	sequence s_tx_msb;
		##1 tx_pcm_out_a_oe_out && tx_pcm_out_a_out == l_ff.tx_sh[7];
	endsequence
	a_msb_first: assert property (@(posedge pcm_bit_clk_in)
		disable iff (!arst_n_in) s_tx_first |-> s_tx_msb) // R10
		else $error("first PCM bit is not the msb");
	a_port_excl: assert property (@(posedge pcm_bit_clk_in)
		disable iff (!arst_n_in)
		!(tx_pcm_out_a_oe_out && tx_pcm_out_b_oe_out)) // R22
		else $error("both transmit ports driven");
	a_write_kill: assert property (@(posedge pcm_bit_clk_in)
		disable iff (!arst_n_in)
		tg_evt[1] |=> !tx_pcm_out_a_oe_out && !tx_pcm_out_b_oe_out) // R25
		else $error("transmit still driven after slot write");
	a_idle_code: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		tx_req && c_ff.tgain == 8'h00 |=>
		c_ff.tx_word == (`PCS_IDLE_RAW ^ $past(mask))) // R28
		else $error("zero gain did not send idle code");
	a_ainv_code: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		tx_req && c_ff.tgain != 8'h00 && src == 8'hff &&
		c_ff.ctrl[5:4] == 2'b10 |=> c_ff.tx_word == 8'haa) // R9
		else $error("inverted A-law full scale wrong");
	a_rx_silence: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		rx_rdy && c_ff.rgain == 8'h00 |=> rx_voice_out == `PCS_IDLE_RAW) // R14
		else $error("zero receive gain not silent");
	a_latch_dir: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		##1 side_latch_pin_oe_out[0] == $past(c_ff.ldir[7])) // R16
		else $error("latch 0 direction not from bit 7");
	a_amp_sleep: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		sleep_state_out && c_ff.ctrl[`PCS_C_AMP] |=> !rx_amp_en_out) // R5
		else $error("amplifier on in sleep");
	a_co_release: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in) cs_n |=> !ctl_data_oe_out)
		else $error("control data driven while deselected");
endmodule
`default_nettype wire

// >>> sim/pcs_hwy_model.sv
// Purpose: far side of the PCM highway: frame marks, rx data, tx capture
// Assumes: bit clock runs free; one mark serves both directions
// Notes: rx lines toggle outside the slot so a late sample never looks valid
`timescale 1ns/1ps
`default_nettype none
module pcs_hwy_model #(
	parameter int FRAME = 40
) (
	// bit clock
	input wire logic bit_clk_in,
	// receive stimulus
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_port_in,
	input wire logic [7:0] rx_ofs_in,
	// highway
	input wire logic tx_a_in,
	input wire logic tx_a_oe_in,
	input wire logic tx_b_in,
	input wire logic tx_b_oe_in,
	output logic mark_out,
	output logic rx_a_out,
	output logic rx_b_out,
	// capture
	output logic [7:0] cap_byte_out,
	output logic cap_port_out,
	output var int cap_pos_out,
	output var int cap_cnt_out,
	output logic both_out
);
	int cnt = 0;
	int nb = 0;
	int pos = 0;
	logic [7:0] sh = 8'h00;
	initial
	begin
		mark_out = 1'b0;
		rx_a_out = 1'b0;
		rx_b_out = 1'b1;
		cap_byte_out = 8'h00;
		cap_port_out = 1'b0;
		cap_pos_out = 0;
		cap_cnt_out = 0;
		both_out = 1'b0;
	end
	always @(posedge bit_clk_in)
	begin : step
		int k;
		logic a;
		logic b;
		k = cnt - 1 - int'(rx_ofs_in);
		a = ~rx_a_out;
		b = ~rx_b_out;
		if (k >= 0 && k < 8 && rx_port_in)
			b = rx_byte_in[7 - k];
		else if (k >= 0 && k < 8)
			a = rx_byte_in[7 - k];
		rx_a_out <= a;
		rx_b_out <= b;
		cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
		mark_out <= (cnt == 0);
		b = tx_b_oe_in ? tx_b_in : tx_a_in;
		// a byte cut short by a mark is dropped, never counted
		if (cnt == 0)
			nb <= 0;
		else if (tx_a_oe_in === 1'b1 || tx_b_oe_in === 1'b1)
		begin
			if (nb == 0)
				pos <= cnt;
			sh <= {sh[6:0], b};
			nb <= (nb == 7) ? 0 : nb + 1;
			if (nb == 7)
			begin
				cap_byte_out <= {sh[6:0], b};
				cap_port_out <= tx_b_oe_in;
				cap_pos_out <= pos;
				cap_cnt_out <= cap_cnt_out + 1;
			end
		end
		if (tx_a_oe_in === 1'b1 && tx_b_oe_in === 1'b1)
			both_out <= 1'b1;
	end
endmodule
`default_nettype wire

// >>> sim/test_pcs_codec_top.sv
// Purpose: register, latch and PCM slot tests of the codec block
// Assumes: frame of 40 bits, one mark drives both directions
// Notes: control port phases are 8 core cycles, above the 5 needed
`timescale 1ns/1ps
`default_nettype none
`include "pcs_codec_regs.svh"
module test_pcs_codec_top;
	logic core_clk_in = 1'b0;
	logic bclk = 1'b0;
	wire pcm_bit_clk_in;
	logic arst_n_in = 1'b0;
	logic ctl_clk_in = 1'b0;
	logic ctl_cs_n_in = 1'b1;
	logic ctl_data_in = 1'b0;
	logic ctl_data_out, ctl_data_oe_out;
	logic [5:0] side_latch_pin_in = 6'b110000;
	logic [5:0] side_latch_pin_out, side_latch_pin_oe_out;
	logic mark, rx_pcm_in_a_in, rx_pcm_in_b_in;
	logic tx_pcm_out_a_out, tx_pcm_out_a_oe_out;
	logic tx_pcm_out_b_out, tx_pcm_out_b_oe_out;
	logic [7:0] tx_voice_in = 8'hff;
	logic [7:0] rx_voice_out;
	logic tx_voice_iso_out, rx_amp_en_out, sleep_state_out;
	logic [1:0] master_div_out;
	logic [7:0] rx_byte = 8'h00;
	logic rx_port = 1'b0;
	logic [7:0] rx_ofs = 8'h00;
	logic [7:0] cap_byte;
	logic cap_port, both;
	int cap_pos, cap_cnt, c;
	int compares = 0;
	int error_cnt = 0;
	logic pwr = 1'b1;
	logic [7:0] ctl_tab [3] = '{8'h48, 8'ha8, 8'hf8};
	logic [7:0] fs_tab [3] = '{8'h80, 8'haa, 8'hff};
	logic [7:0] idle_tab [3] = '{8'hff, 8'hd5, 8'h80};
	always #2 core_clk_in = ~core_clk_in;
	always #80 bclk = ~bclk;
	// offset keeps bit clock edges clear of core edges
	assign #0.7 pcm_bit_clk_in = bclk;
	pcs_codec_top pcs_codec_top_i (.core_clk_in, .pcm_bit_clk_in, .arst_n_in,
		.ctl_clk_in, .ctl_cs_n_in, .ctl_data_in, .ctl_data_out,
		.ctl_data_oe_out, .side_latch_pin_in, .side_latch_pin_out,
		.side_latch_pin_oe_out, .tx_frame_mark_in(mark),
		.rx_frame_mark_in(mark), .rx_pcm_in_a_in, .rx_pcm_in_b_in,
		.tx_pcm_out_a_out, .tx_pcm_out_a_oe_out, .tx_pcm_out_b_out,
		.tx_pcm_out_b_oe_out, .tx_voice_in, .rx_voice_out,
		.tx_voice_iso_out, .rx_amp_en_out, .sleep_state_out,
		.master_div_out);
	pcs_hwy_model pcs_hwy_model_i (.bit_clk_in(pcm_bit_clk_in),
		.rx_byte_in(rx_byte), .rx_port_in(rx_port), .rx_ofs_in(rx_ofs),
		.tx_a_in(tx_pcm_out_a_out), .tx_a_oe_in(tx_pcm_out_a_oe_out),
		.tx_b_in(tx_pcm_out_b_out), .tx_b_oe_in(tx_pcm_out_b_oe_out),
		.mark_out(mark), .rx_a_out(rx_pcm_in_a_in),
		.rx_b_out(rx_pcm_in_b_in), .cap_byte_out(cap_byte),
		.cap_port_out(cap_port), .cap_pos_out(cap_pos),
		.cap_cnt_out(cap_cnt), .both_out(both));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic ctl_byte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
		begin
			ctl_data_in <= b[i];
			ctl_clk_in <= 1'b1;
			repeat (8) @(posedge core_clk_in);
			r[i] = ctl_data_out;
			ctl_clk_in <= 1'b0;
			repeat (8) @(posedge core_clk_in);
		end
	endtask
	task automatic ctl_op(input logic [3:0] a, input logic rd,
		input logic [7:0] d, output logic [7:0] r);
		logic [7:0] junk;
		ctl_cs_n_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		ctl_byte({pwr, a, rd, 2'b10}, junk);
		ctl_byte(d, r);
		ctl_cs_n_in <= 1'b1;
		repeat (8) @(posedge core_clk_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] r;
		ctl_op(a, 1'b0, d, r);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] r;
		ctl_op(a, 1'b1, 8'h00, r);
		check(r, e);
	endtask
	task automatic frames(input int n);
		repeat (n) @(posedge mark);
		@(posedge core_clk_in);
	endtask
	task automatic tx_chk(input logic [7:0] e, input int p, input logic prt);
		int c0;
		// word for a frame is taken at the previous frame's mark
		frames(2);
		c0 = cap_cnt;
		frames(1);
		check(cap_cnt - c0, 1);
		check(cap_byte, e);
		check(cap_pos, p);
		check(cap_port, prt);
	endtask
	initial
	begin
		#400000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		// reset must also span two bit clock edges
		repeat (10) @(posedge core_clk_in);
		repeat (2) @(posedge pcm_bit_clk_in);
		@(posedge core_clk_in);
		arst_n_in <= 1'b1;
		repeat (8) @(posedge core_clk_in);
		check(master_div_out, 2'b10);
		check(sleep_state_out, 1'b1);
		check(rx_amp_en_out, 1'b0);
		check(side_latch_pin_oe_out, 6'b000000);
		check(tx_pcm_out_a_oe_out | tx_pcm_out_b_oe_out, 1'b0);
		rd_chk(`PCS_A_CTRL, 8'h89);
		check(ctl_data_oe_out, 1'b0);
		rd_chk(4'hf, 8'h00);
		wr(`PCS_A_CTRL, 8'h48);
		check(master_div_out, 2'b01);
		check(rx_amp_en_out, 1'b1);
		wr(`PCS_A_LVAL, 8'ha4);
		wr(`PCS_A_LDIR, 8'hf3);
		check(side_latch_pin_oe_out, 6'b001111);
		check(side_latch_pin_out & side_latch_pin_oe_out, 6'b000101);
		rd_chk(`PCS_A_LDIR, 8'hf0);
		rd_chk(`PCS_A_LVAL, 8'hac);
		pwr <= 1'b0;
		wr(`PCS_A_RGAIN, 8'h10);
		check(sleep_state_out, 1'b0);
		wr(`PCS_A_TSLOT, 8'h80);
		wr(`PCS_A_RSLOT, 8'h80);
		frames(2);
		for (int i = 0; i < 3; i++)
		begin
			wr(`PCS_A_CTRL, ctl_tab[i]);
			check(master_div_out, ctl_tab[i][7:6]);
			rx_byte <= fs_tab[i];
			wr(`PCS_A_TGAIN, 8'h00);
			tx_chk(idle_tab[i], 2, 1'b0);
			wr(`PCS_A_TGAIN, 8'h01);
			tx_chk(fs_tab[i], 2, 1'b0);
			check(rx_voice_out, 8'hff);
		end
		wr(`PCS_A_CTRL, 8'h4c);
		rx_byte <= 8'h3c;
		tx_chk(8'h3c, 2, 1'b0);
		check(rx_voice_out, 8'h43);
		wr(`PCS_A_CTRL, 8'h4e);
		tx_chk(8'h3c, 2, 1'b0);
		wr(`PCS_A_RGAIN, 8'h00);
		frames(2);
		check(rx_voice_out, 8'h80);
		wr(`PCS_A_RGAIN, 8'h10);
		wr(`PCS_A_CTRL, 8'h4a);
		rx_byte <= 8'h5a;
		// decoded sample needs one more frame to reach the encoder
		frames(1);
		tx_chk(8'h5a, 2, 1'b0);
		check(tx_voice_iso_out, 1'b1);
		check(rx_voice_out, 8'h25);
		wr(`PCS_A_CTRL, 8'h40);
		rx_port <= 1'b1;
		rx_ofs <= 8'h19;
		rx_byte <= 8'h80;
		frames(1);
		// write lands mid frame, clear of the old slot and the next mark
		repeat (600) @(posedge core_clk_in);
		c = cap_cnt;
		wr(`PCS_A_TSLOT, 8'hc3);
		frames(2);
		check(cap_cnt, c);
		frames(1);
		check(cap_cnt, c + 1);
		check(cap_pos, 27);
		check(cap_port, 1'b1);
		wr(`PCS_A_RSLOT, 8'hc3);
		frames(3);
		check(rx_voice_out, 8'hff);
		wr(`PCS_A_TSLOT, 8'h43);
		c = cap_cnt;
		frames(3);
		check(cap_cnt, c);
		check(both, 1'b0);
		rd_chk(`PCS_A_TSLOT, 8'h43);
		give_verdict();
	end
endmodule
`default_nettype wire
